// File: hw/tile_pkg.sv
package tile_pkg;

  // array make-up
  localparam int LOGIC_ONLY_TILES = 100;
  localparam int MEMORY_TILES     = 40;
  localparam int POOL_BITS        = 5120;
  localparam int STORE_BITS       = POOL_BITS / MEMORY_TILES;

  // tile structure
  localparam int LUT_UNITS      = 4;
  localparam int LUT6_INPUTS    = 6;
  localparam int LUT5_INPUTS    = 5;
  localparam int LUT5_INIT_BITS = 32;
  localparam int TILE_FFS       = 8;
  localparam int CARRY_BITS     = 4;
  localparam int SEG_BITS       = 16;
  localparam int USER_PORTS     = 4;
  localparam int ADDR_W         = 7;
  localparam int TAP_W          = 6;
  localparam int XSEL_W         = 5;
  localparam int XSRC           = 32;

  // crossbar source positions
  localparam int SRC_LUT_BASE = 0;
  localparam int SRC_FF_BASE  = 8;
  localparam int SRC_RD_BASE  = 16;
  localparam int SRC_CARRY    = 20;

  // configuration encodings
  localparam logic [1:0] MODE_LOGIC  = 2'h0;
  localparam logic [1:0] MODE_SHIFT  = 2'h1;
  localparam logic [1:0] MODE_MEMORY = 2'h2;
  localparam logic [1:0] SPLIT_X4    = 2'h0;
  localparam logic [1:0] SPLIT_X2    = 2'h1;
  localparam logic [1:0] SPLIT_X1    = 2'h2;

  // values after reset
  localparam logic [7:0] OUT_RESET  = 8'h00;
  localparam logic [7:0] FF_RESET   = 8'h00;
  localparam logic [3:0] RD_RESET   = 4'h0;
  localparam logic       CARRY_RST  = 1'b0;

  // port that owns segment or array k in the given split
  function automatic logic [1:0] lead_port(input logic [1:0] split, input logic [1:0] k);
    if (split == SPLIT_X4) begin
      return k;
    end else if (split == SPLIT_X2) begin
      return {k[1], 1'b0};
    end
    return 2'h0;
  endfunction : lead_port

  function automatic logic [6:0] map_mem(input logic [1:0] split, input logic [1:0] port,
                                         input logic [6:0] addr);
    if (split == SPLIT_X4) begin
      return {port, addr[4:0]};
    end else if (split == SPLIT_X2) begin
      return {port[1], addr[5:0]};
    end
    return addr;
  endfunction : map_mem

  function automatic logic [6:0] map_tap(input logic [1:0] split, input logic [1:0] port,
                                         input logic [5:0] tap);
    if (split == SPLIT_X4) begin
      return {1'b0, port, tap[3:0]};
    end else if (split == SPLIT_X2) begin
      return {1'b0, port[1], tap[4:0]};
    end
    return {1'b0, tap};
  endfunction : map_tap

  function automatic logic lut5(input logic [31:0] init, input logic [4:0] sel);
    return init[sel];
  endfunction : lut5

endpackage : tile_pkg

// File: hw/tile_store.sv
`timescale 1ns/1ps
`default_nettype none

module tile_store (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  wr_en,
  input  wire logic [27:0] wr_addr,
  input  wire logic [3:0]  wr_bit,
  input  wire logic [3:0]  sh_en,
  input  wire logic [3:0]  sh_in,
  output logic      [3:0]  seg_last,
  input  wire logic [27:0] rd_addr,
  output logic      [3:0]  rd_bit
);

  // contents are not cleared by reset, as with any distributed ram
  logic [tile_pkg::STORE_BITS-1:0] bits_q;
  logic [tile_pkg::STORE_BITS-1:0] bits_d;
  logic [3:0]                      rd_q;

  always_comb begin
    bits_d = bits_q;
    for (int i = 0; i < 4; i++) begin
      if (sh_en[i]) begin
        // newest bit enters at the segment base
        bits_d[i*tile_pkg::SEG_BITS +: tile_pkg::SEG_BITS] =
          {bits_q[i*tile_pkg::SEG_BITS +: tile_pkg::SEG_BITS-1], sh_in[i]};
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (wr_en[i]) begin
        bits_d[wr_addr[i*7 +: 7]] = wr_bit[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    bits_q <= bits_d;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= tile_pkg::RD_RESET;
    end else begin
      for (int i = 0; i < 4; i++) begin
        rd_q[i] <= bits_q[rd_addr[i*7 +: 7]];
      end
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_last
    assign seg_last[i] = bits_q[i*tile_pkg::SEG_BITS + tile_pkg::SEG_BITS - 1];
  end

  assign rd_bit = rd_q;

endmodule : tile_store

`default_nettype wire

// File: hw/logic_tile.sv
`timescale 1ns/1ps
`default_nettype none

module logic_tile #(
  parameter bit HAS_MEMORY = 1'b1
) (
  input  wire logic         MCLK,
  input  wire logic         RST,
  input  wire logic [1:0]   CFG_MODE,
  input  wire logic [1:0]   CFG_SPLIT,
  input  wire logic         CFG_DUAL,
  input  wire logic [3:0]   CFG_CARRY,
  input  wire logic [255:0] LUT_INIT,
  input  wire logic [39:0]  XBAR_SEL,
  input  wire logic [23:0]  LUT_IN,
  input  wire logic         CARRY_IN,
  input  wire logic [3:0]   SR_EN,
  input  wire logic [3:0]   SR_DIN,
  input  wire logic [23:0]  SR_TAP,
  input  wire logic [3:0]   MEM_WE,
  input  wire logic [3:0]   MEM_WD,
  input  wire logic [27:0]  MEM_WADDR,
  input  wire logic [27:0]  MEM_RADDR,
  output logic      [7:0]   TILE_OUT,
  output logic      [7:0]   FF_Q,
  output logic              CARRY_OUT
);

  // one tile's share of the pool must match the store size
  localparam int TILES_TOTAL = tile_pkg::LOGIC_ONLY_TILES + tile_pkg::MEMORY_TILES;
  localparam int POOL_USED   = tile_pkg::MEMORY_TILES * tile_pkg::STORE_BITS;

  logic [1:0] mode_eff;
  logic [1:0] split_eff;
  logic       dual_eff;
  logic       in_shift;
  logic       in_mem;

  // logic-only variant ignores the extra modes; unknown codes fall back
  assign mode_eff  = (HAS_MEMORY && (CFG_MODE == tile_pkg::MODE_SHIFT ||
                      CFG_MODE == tile_pkg::MODE_MEMORY)) ? CFG_MODE
                                                          : tile_pkg::MODE_LOGIC;
  assign split_eff = (CFG_SPLIT == tile_pkg::SPLIT_X4 || CFG_SPLIT == tile_pkg::SPLIT_X2)
                     ? CFG_SPLIT : tile_pkg::SPLIT_X1;
  assign dual_eff  = CFG_DUAL && (split_eff != tile_pkg::SPLIT_X1);
  assign in_shift  = (mode_eff == tile_pkg::MODE_SHIFT);
  assign in_mem    = (mode_eff == tile_pkg::MODE_MEMORY);

  // lookup units and carry chain
  logic [7:0] result;
  logic [4:0] carry;
  logic [3:0] o6;
  logic [3:0] o5a;
  logic [3:0] o5b;

  assign carry[0] = CARRY_IN;

  for (genvar k = 0; k < tile_pkg::LUT_UNITS; k++) begin : g_lut
    logic [4:0] sel5;
    logic       in6;
    logic       prop;
    logic       gen;

    assign sel5   = LUT_IN[k*tile_pkg::LUT6_INPUTS +: tile_pkg::LUT5_INPUTS];
    assign in6    = LUT_IN[k*tile_pkg::LUT6_INPUTS + tile_pkg::LUT5_INPUTS];
    assign o5a[k] = tile_pkg::lut5(LUT_INIT[(2*k)*32 +: 32], sel5);
    assign o5b[k] = tile_pkg::lut5(LUT_INIT[(2*k+1)*32 +: 32], sel5);
    // sixth input picks between the pair
    assign o6[k]  = in6 ? o5b[k] : o5a[k];

    // propagate from the full table, generate from the first half
    assign prop       = o6[k];
    assign gen        = o5a[k];
    assign carry[k+1] = CFG_CARRY[k] ? (prop ? carry[k] : gen) : carry[k];
    assign result[2*k]   = CFG_CARRY[k] ? (prop ^ carry[k]) : o6[k];
    assign result[2*k+1] = o5a[k];
  end

  // one flop per table output
  logic [7:0] ff_q;
  logic       carry_q;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      ff_q    <= tile_pkg::FF_RESET;
      carry_q <= tile_pkg::CARRY_RST;
    end else begin
      ff_q    <= result;
      carry_q <= carry[4];
    end
  end

  // distributed storage steering
  logic [3:0]  sh_en;
  logic [3:0]  sh_in;
  logic [3:0]  seg_last;
  logic [3:0]  wr_en;
  logic [27:0] wr_addr;
  logic [27:0] rd_addr;
  logic [3:0]  rd_bit;

  for (genvar k = 0; k < tile_pkg::USER_PORTS; k++) begin : g_port
    localparam int PREV = (k == 0) ? 0 : k - 1;
    logic [1:0] lead;
    logic       is_lead;
    logic [6:0] maddr;

    assign lead    = tile_pkg::lead_port(split_eff, 2'(k));
    assign is_lead = (lead == 2'(k));

    // wider shifters chain segments; the lead port feeds the first one
    assign sh_en[k] = in_shift && SR_EN[lead];
    assign sh_in[k] = is_lead ? SR_DIN[k] : seg_last[PREV];

    // only the owning port writes its array
    assign wr_en[k] = in_mem && MEM_WE[k] && is_lead;
    assign wr_addr[k*7 +: 7] = tile_pkg::map_mem(split_eff, 2'(k),
                                                 MEM_WADDR[k*7 +: 7]);
    assign maddr = tile_pkg::map_mem(split_eff, 2'(k),
                     dual_eff ? MEM_RADDR[k*7 +: 7] : MEM_WADDR[k*7 +: 7]);
    assign rd_addr[k*7 +: 7] = in_shift
      ? tile_pkg::map_tap(split_eff, 2'(k), SR_TAP[k*6 +: 6])
      : maddr;
  end

  tile_store u_store (
    .clk      (MCLK),
    .rst      (RST),
    .wr_en    (wr_en),
    .wr_addr  (wr_addr),
    .wr_bit   (MEM_WD),
    .sh_en    (sh_en),
    .sh_in    (sh_in),
    .seg_last (seg_last),
    .rd_addr  (rd_addr),
    .rd_bit   (rd_bit)
  );

  // cross-point switch, registered so outputs leave from flops
  logic [tile_pkg::XSRC-1:0] src;
  logic [7:0]                out_d;
  logic [7:0]                out_q;

  assign src = {11'h000, carry_q, rd_bit, ff_q, result};

  for (genvar j = 0; j < 8; j++) begin : g_xbar
    assign out_d[j] = src[XBAR_SEL[j*tile_pkg::XSEL_W +: tile_pkg::XSEL_W]];
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      out_q <= tile_pkg::OUT_RESET;
    end else begin
      out_q <= out_d;
    end
  end

  assign TILE_OUT  = out_q;
  assign FF_Q      = ff_q;
  assign CARRY_OUT = carry_q;

endmodule : logic_tile

`default_nettype wire

// File: tb/fabric_src.sv
`timescale 1ns/1ps
`default_nettype none
// user logic feeding shifter data; lfsr so that neighbouring taps differ
module fabric_src (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic step,
  output logic      bit_o
);
  logic [7:0] pat_q;
  assign bit_o = pat_q[7];
  always_ff @(posedge clk) begin
    if (rst) pat_q <= 8'h4d;
    else if (step) pat_q <= {pat_q[6:0], ^(pat_q & 8'hb8)};
  end
endmodule : fabric_src
`default_nettype wire

// File: tb/logic_tile_props.sv
`timescale 1ns/1ps
`default_nettype none
module logic_tile_props (
  input wire logic         MCLK,
  input wire logic         RST,
  input wire logic [1:0]   CFG_MODE,
  input wire logic [3:0]   CFG_CARRY,
  input wire logic [255:0] LUT_INIT,
  input wire logic [39:0]  XBAR_SEL,
  input wire logic [23:0]  LUT_IN,
  input wire logic         CARRY_IN,
  input wire logic [3:0]   SR_EN,
  input wire logic [3:0]   MEM_WE,
  input wire logic [7:0]   TILE_OUT,
  input wire logic [7:0]   FF_Q,
  input wire logic         CARRY_OUT
);
  default clocking dck @(posedge MCLK); endclocking
  default disable iff (RST);
  // unit 0 only: the other units share the same logic
  wire logic       o6_0 = LUT_IN[5] ? LUT_INIT[{1'b1, LUT_IN[4:0]}] : LUT_INIT[LUT_IN[4:0]];
  wire logic [4:0] sel0 = XBAR_SEL[4:0];
  wire logic       lg   = !RST && (CFG_MODE == 2'h0 || CFG_MODE == 2'h3);
  AST_RESET_CLEARS: assert property ($fell(RST) |-> FF_Q == 8'h00 && !TILE_OUT && !CARRY_OUT)
    else $error("outputs not cleared by reset");
  AST_HALF_A_FLOP: assert property ($past(lg) |-> FF_Q[1] == $past(LUT_INIT[LUT_IN[4:0]]))
    else $error("half a output flop wrong");
  AST_PAIR_OUT: assert property ($past(lg) && !$past(CFG_CARRY[0]) |-> FF_Q[0] == $past(o6_0))
    else $error("paired six input result wrong");
  AST_CARRY_XOR: assert property ($past(lg && CFG_CARRY[0]) |-> FF_Q[0] == $past(o6_0 ^ CARRY_IN))
    else $error("carry sum wrong");
  AST_CARRY_PASS: assert property ($past(lg) && $past(CFG_CARRY) == 4'h0 |-> CARRY_OUT == $past(CARRY_IN))
    else $error("carry bypass wrong");
  AST_XBAR_FLOP: assert property (!$past(RST) && $past(sel0) == 5'h08 |-> TILE_OUT[0] == $past(FF_Q[0]))
    else $error("crossbar flop source wrong");
  AST_XBAR_CARRY: assert property (sel0 == 5'h14 ##1 !$past(RST) |-> TILE_OUT[0] == $past(CARRY_OUT))
    else $error("crossbar carry source wrong");
  AST_XBAR_EMPTY: assert property (sel0 > 5'h14 |=> !TILE_OUT[0])
    else $error("crossbar empty source not low");
  COV_SHIFT: cover property (CFG_MODE == tile_pkg::MODE_SHIFT && SR_EN[0]);
  COV_MEM: cover property (CFG_MODE == tile_pkg::MODE_MEMORY && MEM_WE[1]);
  COV_CARRY: cover property (CFG_CARRY == 4'hf && CARRY_OUT);
endmodule : logic_tile_props
bind logic_tile logic_tile_props props_u (.MCLK(MCLK), .RST(RST), .CFG_MODE(CFG_MODE),
  .CFG_CARRY(CFG_CARRY), .LUT_INIT(LUT_INIT), .XBAR_SEL(XBAR_SEL), .LUT_IN(LUT_IN),
  .CARRY_IN(CARRY_IN), .SR_EN(SR_EN), .MEM_WE(MEM_WE), .TILE_OUT(TILE_OUT), .FF_Q(FF_Q),
  .CARRY_OUT(CARRY_OUT));
`default_nettype wire

// File: tb/logic_tile_tb.sv
`timescale 1ns/1ps
`default_nettype none
module logic_tile_tb;
  localparam logic [31:0] HA = 32'h9ac3_5e71;
  localparam logic [31:0] HB = 32'h0f0f_3c5a;
  logic         MCLK = 1'b0, RST = 1'b1, CFG_DUAL = 1'b0, CARRY_IN = 1'b0, CARRY_OUT, sbit;
  logic [1:0]   CFG_MODE = 2'h0, CFG_SPLIT = 2'h0;
  logic [3:0]   CFG_CARRY = 4'h0, SR_EN = 4'h0, MEM_WE = 4'h0, MEM_WD = 4'h0;
  logic [255:0] LUT_INIT = {4{HB, HA}};
  logic [39:0]  XBAR_SEL = 40'h1f;
  logic [23:0]  LUT_IN = 24'h0, SR_TAP = 24'h0;
  logic [27:0]  MEM_WADDR = 28'h0, MEM_RADDR = 28'h0;
  logic [7:0]   TILE_OUT, FF_Q;
  wire logic [3:0] SR_DIN = {4{sbit}};
  int bad_count = 0, check_count = 0, cyc = 0;
  logic_tile dut_u (.MCLK(MCLK), .RST(RST), .CFG_MODE(CFG_MODE), .CFG_SPLIT(CFG_SPLIT),
    .CFG_DUAL(CFG_DUAL), .CFG_CARRY(CFG_CARRY), .LUT_INIT(LUT_INIT), .XBAR_SEL(XBAR_SEL),
    .LUT_IN(LUT_IN), .CARRY_IN(CARRY_IN), .SR_EN(SR_EN), .SR_DIN(SR_DIN), .SR_TAP(SR_TAP),
    .MEM_WE(MEM_WE), .MEM_WD(MEM_WD), .MEM_WADDR(MEM_WADDR), .MEM_RADDR(MEM_RADDR),
    .TILE_OUT(TILE_OUT), .FF_Q(FF_Q), .CARRY_OUT(CARRY_OUT));
  fabric_src src_u (.clk(MCLK), .rst(RST), .step(SR_EN[0]), .bit_o(sbit));
  always #2.5 MCLK = ~MCLK;
  task automatic give_verdict;
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  // land after the edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : tick
  task automatic t_logic;
    logic [5:0] s;
    for (int i = 0; i < 64; i++) begin
      s = 6'(i);
      @(posedge MCLK);
      XBAR_SEL <= 40'h08;
      LUT_IN <= {4{s}};
      tick(1);
      check(FF_Q, {4{HA[s[4:0]], s[5] ? HB[s[4:0]] : HA[s[4:0]]}});
    end
  endtask : t_logic
  task automatic t_carry;
    logic [5:0] s;
    for (int j = 0; j < 4; j++) begin
      s = j[1] ? 6'h21 : 6'h3f;
      @(posedge MCLK);
      CFG_CARRY <= 4'hf;
      XBAR_SEL <= 40'h14;
      LUT_IN <= {4{s}};
      CARRY_IN <= j[0];
      tick(1);
      check(FF_Q, j[1] ? (j[0] ? 8'h00 : 8'h55) : {7'h7f, j[0]});
      check({7'h0, CARRY_OUT}, {7'h0, j[1] ? j[0] : 1'b1});
    end
  endtask : t_carry
  // mid-run reset; the first edge after release already loads the flops
  task automatic t_reset;
    @(posedge MCLK);
    RST <= 1'b1;
    LUT_IN <= {4{6'h3f}};
    tick(1);
    check(FF_Q, tile_pkg::FF_RESET);
    check(TILE_OUT, tile_pkg::OUT_RESET);
    check({7'h0, CARRY_OUT}, {7'h0, tile_pkg::CARRY_RST});
    @(posedge MCLK);
    RST <= 1'b0;
    tick(1);
    check(FF_Q, 8'hff);
    check({7'h0, CARRY_OUT}, 8'h01);
  endtask : t_reset
  task automatic t_shift(input logic [1:0] split, input int n);
    logic hist [64];
    @(posedge MCLK);
    CFG_CARRY <= 4'h0;
    CFG_MODE <= 2'h1;
    CFG_SPLIT <= split;
    XBAR_SEL <= 40'h10;
    SR_EN <= 4'h1;
    for (int i = 0; i < n; i++) begin
      @(posedge MCLK);
      hist[i] = SR_DIN[0];
    end
    SR_EN <= 4'h0;
    SR_TAP <= 24'(n - 1);
    tick(3);
    check({7'h0, TILE_OUT[0]}, {7'h0, hist[0]});
    @(posedge MCLK);
    SR_TAP <= 24'h0;
    tick(3);
    check({7'h0, TILE_OUT[0]}, {7'h0, hist[n - 1]});
    @(posedge MCLK);
    SR_EN <= 4'h1;
    @(posedge MCLK);
    SR_EN <= 4'h0;
    SR_TAP <= 24'(n - 1);
    tick(3);
    check({7'h0, TILE_OUT[0]}, {7'h0, hist[1]});
  endtask : t_shift
  // read address differs from write address so a wrong port choice shows
  task automatic t_mem(input logic [1:0] split, input logic [1:0] p, input logic [6:0] a,
                       input logic v);
    @(posedge MCLK);
    CFG_MODE <= 2'h2;
    CFG_SPLIT <= split;
    CFG_DUAL <= 1'b1;
    XBAR_SEL <= 40'(5'h10 + p);
    MEM_WADDR <= 28'(a) << (7 * p);
    MEM_RADDR <= 28'(~a) << (7 * p);
    MEM_WD <= {4{v}};
    MEM_WE <= 4'h1 << p;
    @(posedge MCLK);
    MEM_WE <= 4'h0;
    // both x1 codes ignore the dual flag, so their read stays on the write address
    if (split < 2'h2) begin
      MEM_WADDR <= 28'(~a) << (7 * p);
      MEM_RADDR <= 28'(a) << (7 * p);
    end
    tick(3);
    check({7'h0, TILE_OUT[0]}, {7'h0, v});
  endtask : t_mem
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    t_logic();
    t_carry();
    t_reset();
    t_shift(2'h0, 16);
    t_shift(2'h1, 32);
    t_shift(2'h2, 64);
    t_mem(2'h2, 2'h0, 7'h64, 1'b1);
    t_mem(2'h3, 2'h0, 7'h1b, 1'b0);
    t_mem(2'h0, 2'h1, 7'h03, 1'b1);
    t_mem(2'h1, 2'h2, 7'h25, 1'b1);
    give_verdict();
  end
endmodule : logic_tile_tb
`default_nettype wire
